// ===== logic/cwm_pkg.sv
// Package for the word, multiply, rotate and bit-move execution datapath.
// Assumes one CPU clock; the sequencer supplies operands and wait counts.
package cwm_pkg;

  localparam int CWM_CNT_W  = 7;
  localparam int CWM_WAIT_W = 4;

  typedef enum logic [4:0] {
    OP_ADD_WORD        = 5'b00000,
    OP_SUB_WORD        = 5'b00001,
    OP_COMPARE_WORD    = 5'b00010,
    OP_MULTIPLY        = 5'b00011,
    OP_DIVIDE_WORD     = 5'b00100,
    OP_PLUS_ONE_REG    = 5'b00101,
    OP_PLUS_ONE_MEM    = 5'b00110,
    OP_MINUS_ONE_REG   = 5'b00111,
    OP_MINUS_ONE_MEM   = 5'b01000,
    OP_PAIR_PLUS_ONE   = 5'b01001,
    OP_PAIR_MINUS_ONE  = 5'b01010,
    OP_ROTATE_RIGHT    = 5'b01011,
    OP_ROTATE_LEFT     = 5'b01100,
    OP_ROTATE_RIGHT_CY = 5'b01101,
    OP_ROTATE_LEFT_CY  = 5'b01110,
    OP_NIBBLE_RIGHT    = 5'b01111,
    OP_NIBBLE_LEFT     = 5'b10000,
    OP_BCD_FIX_ADD     = 5'b10001,
    OP_BCD_FIX_SUB     = 5'b10010,
    OP_BIT_TO_CARRY    = 5'b10011,
    OP_CARRY_TO_BIT    = 5'b10100
  } cwm_op_type;

  typedef enum logic [2:0] {
    SP_ACC     = 3'b000,
    SP_SHORT   = 3'b001,
    SP_SPECIAL = 3'b010,
    SP_STATUS  = 3'b011,
    SP_POINTER = 3'b100
  } cwm_space_type;

  // Instruction lengths in CPU clocks
  localparam logic [6:0] CLK_WORD      = 7'h06;
  localparam logic [6:0] CLK_MUL       = 7'h10;
  localparam logic [6:0] CLK_DIV       = 7'h19;
  localparam logic [6:0] CLK_INC_REG   = 7'h02;
  localparam logic [6:0] CLK_INC_FAST  = 7'h04;
  localparam logic [6:0] CLK_INC_SLOW  = 7'h06;
  localparam logic [6:0] CLK_PAIR      = 7'h04;
  localparam logic [6:0] CLK_ROT       = 7'h02;
  localparam logic [6:0] CLK_NIB_FAST  = 7'h0A;
  localparam logic [6:0] CLK_NIB_SLOW  = 7'h0C;
  localparam logic [6:0] CLK_BCD       = 7'h04;
  localparam logic [6:0] CLK_BIT_ACC   = 7'h04;
  localparam logic [6:0] CLK_BIT_FAST  = 7'h06;
  localparam logic [6:0] CLK_BIT_LOAD  = 7'h07;
  localparam logic [6:0] CLK_BIT_STORE = 7'h08;
  localparam logic [6:0] CLK_ILLEGAL   = 7'h01;

  // Decimal adjust constants
  localparam logic [7:0] BCD_LO_FIX    = 8'h06;
  localparam logic [7:0] BCD_HI_FIX    = 8'h60;
  localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
  localparam logic [7:0] BCD_BYTE_MAX  = 8'h99;

  // Divide by zero answer
  localparam logic [15:0] DIV_ZERO_QUOT = 16'hFFFF;

endpackage : cwm_pkg

// ===== logic/cwm_datapath.sv
// Execution datapath: word arithmetic, multiply/divide, inc/dec, rotates,
// decimal adjust and single-bit moves through carry.
// Assumes the sequencer holds operands stable with start and reads results on done.
// Operation
// - Word add-immediate updates pair and zero, half-carry, carry; six clocks.
// - Word subtract stores difference, borrow in carry; compare only sets flags.
// - Multiply accumulator byte by X into pair, flags kept, sixteen clocks.
// - Divide pair by C: quotient to pair, remainder to C, 25 clocks.
// - Byte increment updates zero and half-carry, keeps carry; 2, 4 or 6 clocks.
// - Byte decrement updates zero and half-carry, keeps carry; timing as increment.
// - Rotate right: bit 0 to bit 7 and carry, others down, two clocks.
// - Rotate left: bit 7 to bit 0 and carry, others up, two clocks.
// - Rotates through carry treat carry as a ninth bit.
// - Right nibble rotate through pointer memory and accumulator low nibble.
// - Left nibble rotate through pointer memory, ten clocks on fast RAM, twelve otherwise.
// - Decimal adjust after add fixes accumulator, sets zero, half-carry, carry.
// - Decimal adjust after subtract fixes accumulator and flags, four clocks.
// - Bit move copies selected bit to carry or carry into bit.
// - One instruction clock is one CPU clock period; counts for internal code.
// - External reads by nibble rotates and pointer bit moves add the read wait count to the instruction length.
// - External writes by those same instructions add the write wait count alongside read waits.
`timescale 1ns/1ps
module cwm_datapath (
  input  wire logic                          mclk,
  input  wire logic                          reset_n,
  input  wire logic                          start,
  input  wire cwm_pkg::cwm_op_type           op,
  input  wire cwm_pkg::cwm_space_type        space,
  input  wire logic [2:0]                    bit_sel,
  input  wire logic                          fast_ram,
  input  wire logic                          ext_area,
  input  wire logic [cwm_pkg::CWM_WAIT_W-1:0] read_waits,
  input  wire logic [cwm_pkg::CWM_WAIT_W-1:0] write_waits,
  input  wire logic [15:0]                   acc_word_pair,
  input  wire logic [15:0]                   operand,
  input  wire logic [7:0]                    mem_rdata,
  input  wire logic                          zero_in,
  input  wire logic                          half_carry_in,
  input  wire logic                          carry_in,
  output logic                               busy,
  output logic                               done,
  output logic [15:0]                        result_q,
  output logic                               result_we_q,
  output logic [7:0]                         remainder_q,
  output logic                               remainder_we_q,
  output logic [7:0]                         mem_wdata_q,
  output logic                               mem_we_q,
  output logic                               zero_flag_q,
  output logic                               half_carry_flag_q,
  output logic                               carry_flag_q
);
  import cwm_pkg::*;

  logic [CWM_CNT_W-1:0] cnt_q;
  logic                 done_q;
  logic                 take;
  logic [7:0]           acc_b;
  logic [7:0]           x_b;
  logic [16:0]          wsum;
  logic [4:0]           nsum;
  logic [7:0]           bsrc;
  logic [7:0]           bset;
  logic [7:0]           bcd_lo;
  logic [7:0]           bcd_hi;
  logic [6:0]           base;
  logic                 rd_mem;
  logic                 wr_mem;
  logic [CWM_CNT_W-1:0] len;
  logic [15:0]          res_d;
  logic                 res_we_d;
  logic [7:0]           rem_d;
  logic                 rem_we_d;
  logic [7:0]           mem_d;
  logic                 mem_we_d;
  logic                 z_d;
  logic                 ac_d;
  logic                 cy_d;

  assign acc_b = acc_word_pair[15:8];
  assign x_b   = acc_word_pair[7:0];
  assign busy  = (cnt_q != '0);
  assign take  = start && !busy;
  assign done  = done_q;
  assign bsrc  = (space == SP_ACC) ? acc_b : mem_rdata;

  // Instruction length from the operation, the space and the memory area
  always_comb begin
    base   = CLK_ILLEGAL;
    rd_mem = 1'b0;
    wr_mem = 1'b0;
    unique case (op)
      OP_ADD_WORD, OP_SUB_WORD, OP_COMPARE_WORD: base = CLK_WORD;
      OP_MULTIPLY:     base = CLK_MUL;
      OP_DIVIDE_WORD:  base = CLK_DIV;
      OP_PLUS_ONE_REG, OP_MINUS_ONE_REG: base = CLK_INC_REG;
      OP_PLUS_ONE_MEM, OP_MINUS_ONE_MEM: begin
        base = fast_ram ? CLK_INC_FAST : CLK_INC_SLOW;
      end
      OP_PAIR_PLUS_ONE, OP_PAIR_MINUS_ONE: base = CLK_PAIR;
      OP_ROTATE_RIGHT, OP_ROTATE_LEFT,
      OP_ROTATE_RIGHT_CY, OP_ROTATE_LEFT_CY: base = CLK_ROT;
      OP_NIBBLE_RIGHT, OP_NIBBLE_LEFT: begin
        base   = fast_ram ? CLK_NIB_FAST : CLK_NIB_SLOW;
        rd_mem = 1'b1;
        wr_mem = 1'b1;
      end
      OP_BCD_FIX_ADD, OP_BCD_FIX_SUB: base = CLK_BCD;
      OP_BIT_TO_CARRY, OP_CARRY_TO_BIT: begin
        if (space == SP_ACC) begin
          base = CLK_BIT_ACC;
        end else if (fast_ram && (space == SP_SHORT || space == SP_POINTER)) begin
          base = CLK_BIT_FAST;
        end else begin
          base = (op == OP_BIT_TO_CARRY) ? CLK_BIT_LOAD : CLK_BIT_STORE;
        end
        rd_mem = (space == SP_POINTER);
        wr_mem = (space == SP_POINTER) && (op == OP_CARRY_TO_BIT);
      end
      default: base = CLK_ILLEGAL;
    endcase
  end

  // Wait states only on the external expansion area, never on fast RAM
  always_comb begin
    len = CWM_CNT_W'(base);
    if (ext_area && !fast_ram && rd_mem) begin
      len = len + CWM_CNT_W'(read_waits);
    end
    if (ext_area && !fast_ram && wr_mem) begin
      len = len + CWM_CNT_W'(write_waits);
    end
  end

  // Results and flags of each operation
  always_comb begin
    res_d    = '0;
    res_we_d = 1'b0;
    rem_d    = '0;
    rem_we_d = 1'b0;
    mem_d    = '0;
    mem_we_d = 1'b0;
    z_d      = zero_in;
    ac_d     = half_carry_in;
    cy_d     = carry_in;
    wsum     = '0;
    nsum     = '0;
    bcd_lo   = '0;
    bcd_hi   = '0;
    bset     = bsrc;
    unique case (op)
      OP_ADD_WORD: begin
        wsum     = {1'b0, acc_word_pair} + {1'b0, operand};
        nsum     = {1'b0, acc_word_pair[3:0]} + {1'b0, operand[3:0]};
        res_d    = wsum[15:0];
        res_we_d = 1'b1;
        z_d      = (wsum[15:0] == 16'h0000);
        ac_d     = nsum[4];
        cy_d     = wsum[16];
      end
      OP_SUB_WORD, OP_COMPARE_WORD: begin
        wsum     = {1'b0, acc_word_pair} - {1'b0, operand};
        nsum     = {1'b0, acc_word_pair[3:0]} - {1'b0, operand[3:0]};
        res_d    = wsum[15:0];
        res_we_d = (op == OP_SUB_WORD);
        z_d      = (wsum[15:0] == 16'h0000);
        ac_d     = nsum[4];
        cy_d     = wsum[16];
      end
      OP_MULTIPLY: begin
        res_d    = {8'h00, acc_b} * {8'h00, x_b};
        res_we_d = 1'b1;
      end
      OP_DIVIDE_WORD: begin
        if (operand[7:0] == 8'h00) begin
          res_d = DIV_ZERO_QUOT;
          rem_d = x_b;
        end else begin
          res_d = acc_word_pair / {8'h00, operand[7:0]};
          rem_d = 8'((acc_word_pair % {8'h00, operand[7:0]}));
        end
        res_we_d = 1'b1;
        rem_we_d = 1'b1;
      end
      OP_PLUS_ONE_REG: begin
        res_d    = {8'h00, operand[7:0] + 8'h01};
        res_we_d = 1'b1;
        z_d      = (operand[7:0] == 8'hFF);
        ac_d     = (operand[3:0] == 4'hF);
      end
      OP_PLUS_ONE_MEM: begin
        mem_d    = mem_rdata + 8'h01;
        mem_we_d = 1'b1;
        z_d      = (mem_rdata == 8'hFF);
        ac_d     = (mem_rdata[3:0] == 4'hF);
      end
      OP_MINUS_ONE_REG: begin
        res_d    = {8'h00, operand[7:0] - 8'h01};
        res_we_d = 1'b1;
        z_d      = (operand[7:0] == 8'h01);
        ac_d     = (operand[3:0] == 4'h0);
      end
      OP_MINUS_ONE_MEM: begin
        mem_d    = mem_rdata - 8'h01;
        mem_we_d = 1'b1;
        z_d      = (mem_rdata == 8'h01);
        ac_d     = (mem_rdata[3:0] == 4'h0);
      end
      OP_PAIR_PLUS_ONE: begin
        res_d    = operand + 16'h0001;
        res_we_d = 1'b1;
      end
      OP_PAIR_MINUS_ONE: begin
        res_d    = operand - 16'h0001;
        res_we_d = 1'b1;
      end
      OP_ROTATE_RIGHT: begin
        res_d    = {8'h00, acc_b[0], acc_b[7:1]};
        res_we_d = 1'b1;
        cy_d     = acc_b[0];
      end
      OP_ROTATE_LEFT: begin
        res_d    = {8'h00, acc_b[6:0], acc_b[7]};
        res_we_d = 1'b1;
        cy_d     = acc_b[7];
      end
      OP_ROTATE_RIGHT_CY: begin
        res_d    = {8'h00, carry_in, acc_b[7:1]};
        res_we_d = 1'b1;
        cy_d     = acc_b[0];
      end
      OP_ROTATE_LEFT_CY: begin
        res_d    = {8'h00, acc_b[6:0], carry_in};
        res_we_d = 1'b1;
        cy_d     = acc_b[7];
      end
      OP_NIBBLE_RIGHT: begin
        res_d    = {8'h00, acc_b[7:4], mem_rdata[3:0]};
        mem_d    = {acc_b[3:0], mem_rdata[7:4]};
        res_we_d = 1'b1;
        mem_we_d = 1'b1;
      end
      OP_NIBBLE_LEFT: begin
        res_d    = {8'h00, acc_b[7:4], mem_rdata[7:4]};
        mem_d    = {mem_rdata[3:0], acc_b[3:0]};
        res_we_d = 1'b1;
        mem_we_d = 1'b1;
      end
      OP_BCD_FIX_ADD: begin
        bcd_lo   = (half_carry_in || acc_b[3:0] > BCD_DIGIT_MAX) ? BCD_LO_FIX : 8'h00;
        bcd_hi   = (carry_in || acc_b > BCD_BYTE_MAX) ? BCD_HI_FIX : 8'h00;
        nsum     = {1'b0, acc_b[3:0]} + {1'b0, bcd_lo[3:0]};
        res_d    = {8'h00, acc_b + bcd_lo + bcd_hi};
        res_we_d = 1'b1;
        z_d      = ((acc_b + bcd_lo + bcd_hi) == 8'h00);
        ac_d     = nsum[4];
        cy_d     = (bcd_hi != 8'h00);
      end
      OP_BCD_FIX_SUB: begin
        bcd_lo   = half_carry_in ? BCD_LO_FIX : 8'h00;
        bcd_hi   = carry_in ? BCD_HI_FIX : 8'h00;
        nsum     = {1'b0, acc_b[3:0]} - {1'b0, bcd_lo[3:0]};
        res_d    = {8'h00, acc_b - bcd_lo - bcd_hi};
        res_we_d = 1'b1;
        z_d      = ((acc_b - bcd_lo - bcd_hi) == 8'h00);
        ac_d     = nsum[4];
        cy_d     = carry_in;
      end
      OP_BIT_TO_CARRY: begin
        cy_d = bsrc[bit_sel];
      end
      OP_CARRY_TO_BIT: begin
        bset[bit_sel] = carry_in;
        if (space == SP_ACC) begin
          res_d    = {8'h00, bset};
          res_we_d = 1'b1;
        end else begin
          mem_d    = bset;
          mem_we_d = 1'b1;
        end
      end
      default: begin
        res_we_d = 1'b0;
      end
    endcase
  end

  // Cycle counter stretches busy over the whole instruction
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= '0;
    end else if (take) begin
      cnt_q <= len;
    end else if (busy) begin
      cnt_q <= cnt_q - CWM_CNT_W'(1);
    end
  end

  // One-cycle completion pulse in the clock after the last busy clock
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      done_q <= 1'b0;
    end else begin
      done_q <= !take && (cnt_q == CWM_CNT_W'(1));
    end
  end

  // Results captured when the operation is taken
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      result_q       <= '0;
      result_we_q    <= 1'b0;
      remainder_q    <= '0;
      remainder_we_q <= 1'b0;
      mem_wdata_q    <= '0;
      mem_we_q       <= 1'b0;
    end else if (take) begin
      result_q       <= res_d;
      result_we_q    <= res_we_d;
      remainder_q    <= rem_d;
      remainder_we_q <= rem_we_d;
      mem_wdata_q    <= mem_d;
      mem_we_q       <= mem_we_d;
    end
  end

  // Flags captured when the operation is taken
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      zero_flag_q       <= 1'b0;
      half_carry_flag_q <= 1'b0;
      carry_flag_q      <= 1'b0;
    end else if (take) begin
      zero_flag_q       <= z_d;
      half_carry_flag_q <= ac_d;
      carry_flag_q      <= cy_d;
    end
  end

endmodule : cwm_datapath

// ===== tb/cwm_datapath_chk.sv
// Port checker for the execution datapath.
// Assumes one clock domain and an asynchronous active-low reset.
`timescale 1ns/1ps
module cwm_datapath_chk
  import cwm_pkg::*;
(
  input wire logic                   mclk,
  input wire logic                   reset_n,
  input wire logic                   start,
  input wire cwm_pkg::cwm_op_type    op,
  input wire cwm_pkg::cwm_space_type space,
  input wire logic [2:0]             bit_sel,
  input wire logic                   fast_ram,
  input wire logic                   ext_area,
  input wire logic [3:0]             read_waits,
  input wire logic [3:0]             write_waits,
  input wire logic [15:0]            acc_word_pair,
  input wire logic [15:0]            operand,
  input wire logic                   half_carry_in,
  input wire logic                   carry_in,
  input wire logic                   busy,
  input wire logic                   done,
  input wire logic [15:0]            result_q,
  input wire logic                   half_carry_flag_q,
  input wire logic                   carry_flag_q
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  logic take;
  assign take = start & ~busy;
  property p_add;
    take && op == OP_ADD_WORD |=> {carry_flag_q, result_q} ==
      {1'b0, $past(acc_word_pair)} + {1'b0, $past(operand)};
  endproperty
  a_add: assert property (p_add) else $error("word add wrong");
  property p_word_len;
    take && op inside {OP_ADD_WORD, OP_SUB_WORD, OP_COMPARE_WORD} |=>
      busy [*6] ##1 (done && !busy);
  endproperty
  a_word_len: assert property (p_word_len) else $error("word op length");
  property p_mul;
    take && op == OP_MULTIPLY |=> result_q == $past(acc_word_pair[15:8]) *
      $past(acc_word_pair[7:0]) && carry_flag_q == $past(carry_in);
  endproperty
  a_mul: assert property (p_mul) else $error("multiply wrong");
  property p_div_len;
    take && op == OP_DIVIDE_WORD |-> ##26 done;
  endproperty
  a_div_len: assert property (p_div_len) else $error("divide length");
  property p_inc;
    take && op == OP_PLUS_ONE_REG |=> result_q[7:0] == $past(operand[7:0]) + 8'h01
      && carry_flag_q == $past(carry_in);
  endproperty
  a_inc: assert property (p_inc) else $error("increment wrong");
  property p_ror;
    take && op == OP_ROTATE_RIGHT |=> carry_flag_q == $past(acc_word_pair[8]) &&
      result_q[7:0] == {$past(acc_word_pair[8]), $past(acc_word_pair[15:9])};
  endproperty
  a_ror: assert property (p_ror) else $error("rotate right wrong");
  property p_pair;
    take && op == OP_PAIR_MINUS_ONE |=> result_q == $past(operand) - 16'h0001 &&
      half_carry_flag_q == $past(half_carry_in) && carry_flag_q == $past(carry_in);
  endproperty
  a_pair: assert property (p_pair) else $error("pair decrement wrong");
  property p_nib_len;
    take && op == OP_NIBBLE_RIGHT && ext_area && !fast_ram && read_waits == 4'h3
      && write_waits == 4'h2 |-> ##18 done;
  endproperty
  a_nib_len: assert property (p_nib_len) else $error("wait length");
  property p_bit;
    take && op == OP_BIT_TO_CARRY && space == SP_ACC |=>
      carry_flag_q == $past(acc_word_pair[8 + bit_sel]);
  endproperty
  a_bit: assert property (p_bit) else $error("bit load wrong");
endmodule : cwm_datapath_chk
bind cwm_datapath cwm_datapath_chk i_cwm_datapath_chk (.mclk, .reset_n, .start, .op,
  .space, .bit_sel, .fast_ram, .ext_area, .read_waits, .write_waits, .acc_word_pair,
  .operand, .half_carry_in, .carry_in, .busy, .done, .result_q, .half_carry_flag_q,
  .carry_flag_q);

// ===== tb/cwm_mem_model.sv
// Memory byte model on the far side of the datapath.
// Assumes one addressed byte; a write lands when done shows mem_we_q.
`timescale 1ns/1ps
module cwm_mem_model (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic       done,
  input  wire logic       mem_we_q,
  input  wire logic [7:0] mem_wdata_q,
  output logic      [7:0] rdata
);
  logic [7:0] mem_q;
  assign rdata = mem_q;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mem_q <= 8'hA5;
    end else if (done && mem_we_q) begin
      mem_q <= mem_wdata_q;
    end
  end
endmodule : cwm_mem_model

// ===== tb/cpu_word_mul_rotate_bit_ops_tb.sv
// Self-checking bench for the execution datapath.
// Assumes the memory model starts at A5 and tracks every write.
`timescale 1ns/1ps
module cpu_word_mul_rotate_bit_ops_tb;
  import cwm_pkg::*;
  logic          mclk = 1'b0, reset_n = 1'b0, start = 1'b0, fast_ram = 1'b0;
  logic          ext_area = 1'b0, zero_in = 1'b0, half_carry_in = 1'b0, carry_in = 1'b0;
  cwm_op_type    op = OP_ADD_WORD;
  cwm_space_type space = SP_ACC;
  logic [2:0]    bit_sel = 3'h0;
  logic [3:0]    read_waits = 4'h0, write_waits = 4'h0;
  logic [15:0]   acc_word_pair = 16'h0000, operand = 16'h0000, result_q;
  logic [7:0]    mem_rdata, remainder_q, mem_wdata_q;
  logic          busy, done, result_we_q, remainder_we_q, mem_we_q;
  logic          zero_flag_q, half_carry_flag_q, carry_flag_q;
  logic [2:0]    fl;
  int            n_fail = 0, checks = 0;
  assign fl = {zero_flag_q, half_carry_flag_q, carry_flag_q};
  always #2 mclk = ~mclk;
  cwm_datapath i_cwm_datapath (.mclk, .reset_n, .start, .op, .space, .bit_sel, .fast_ram,
    .ext_area, .read_waits, .write_waits, .acc_word_pair, .operand, .mem_rdata, .zero_in,
    .half_carry_in, .carry_in, .busy, .done, .result_q, .result_we_q, .remainder_q,
    .remainder_we_q, .mem_wdata_q, .mem_we_q, .zero_flag_q, .half_carry_flag_q,
    .carry_flag_q);
  cwm_mem_model i_cwm_mem_model (.mclk, .reset_n, .done, .mem_we_q, .mem_wdata_q,
    .rdata(mem_rdata));
  task automatic end_of_test;
    $display("Checks %0d, failures %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test
  task automatic chk_w(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t value %h, expected %h", $time, got, exp);
    end
  endtask : chk_w
  task automatic chk_f(input logic [2:0] got, input logic [2:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t flags %b, expected %b", $time, got, exp);
    end
  endtask : chk_f
  task automatic run(input cwm_op_type o, input cwm_space_type s, input logic [2:0] b,
                     input logic fr, input logic ex, input logic [15:0] a,
                     input logic [15:0] d, input logic h, input logic c, input int len);
    int n;
    @(posedge mclk);
    op <= o;
    space <= s;
    bit_sel <= b;
    fast_ram <= fr;
    ext_area <= ex;
    acc_word_pair <= a;
    operand <= d;
    half_carry_in <= h;
    carry_in <= c;
    start <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
    #1;
    n = 0;
    while (done !== 1'b1 && n < 100) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n >= 100) begin
      n_fail++;
      $display("[ERR] %0t no completion", $time);
      end_of_test();
    end
    chk_w(16'(n), 16'(len));
  endtask : run
  task automatic t_word;
    run(OP_ADD_WORD, SP_ACC, 3'h0, 1'b1, 1'b0, 16'hFFFF, 16'h0001, 1'b0, 1'b0, 6);
    chk_w(result_q, 16'h0000);
    chk_f(fl, 3'b111);
    run(OP_SUB_WORD, SP_ACC, 3'h0, 1'b1, 1'b0, 16'h0000, 16'h0001, 1'b0, 1'b0, 6);
    chk_w(result_q, 16'hFFFF);
    chk_f(fl, 3'b011);
    run(OP_COMPARE_WORD, SP_ACC, 3'h0, 1'b1, 1'b0, 16'h1234, 16'h1234, 1'b0, 1'b1, 6);
    chk_w(16'(result_we_q), 16'h0000);
    chk_f(fl, 3'b100);
  endtask : t_word
  task automatic t_muldiv;
    @(posedge mclk);
    zero_in <= 1'b1;
    run(OP_MULTIPLY, SP_ACC, 3'h0, 1'b1, 1'b0, 16'hFFFF, 16'h0000, 1'b1, 1'b1, 16);
    chk_w(result_q, 16'hFE01);
    chk_f(fl, 3'b111);
    run(OP_DIVIDE_WORD, SP_ACC, 3'h0, 1'b1, 1'b0, 16'h1234, 16'h0010, 1'b0, 1'b0, 25);
    chk_w(result_q, 16'h0123);
    chk_w({remainder_we_q, 7'h00, remainder_q}, 16'h8004);
    chk_f(fl, 3'b100);
    run(OP_DIVIDE_WORD, SP_ACC, 3'h0, 1'b1, 1'b0, 16'h1234, 16'h0000, 1'b0, 1'b0, 25);
    chk_w(result_q, DIV_ZERO_QUOT);
    chk_w({remainder_we_q, 7'h00, remainder_q}, 16'h8034);
    @(posedge mclk);
    zero_in <= 1'b0;
  endtask : t_muldiv
  task automatic t_nibble;
    @(posedge mclk);
    read_waits <= 4'h3;
    write_waits <= 4'h2;
    run(OP_NIBBLE_RIGHT, SP_POINTER, 3'h0, 1'b0, 1'b1, 16'h0700, 16'h0000, 1'b0, 1'b0,
        17);
    chk_w(result_q, 16'h0005);
    chk_w(16'(mem_wdata_q), 16'h007A);
    run(OP_NIBBLE_LEFT, SP_POINTER, 3'h0, 1'b1, 1'b0, 16'h0500, 16'h0000, 1'b0, 1'b0,
        10);
    chk_w(result_q, 16'h0007);
    chk_w(16'(mem_wdata_q), 16'h00A5);
  endtask : t_nibble
  task automatic t_incdec;
    run(OP_PLUS_ONE_REG, SP_ACC, 3'h0, 1'b1, 1'b0, 16'h0000, 16'h000F, 1'b0, 1'b1, 2);
    chk_w(result_q, 16'h0010);
    chk_f(fl, 3'b011);
    run(OP_MINUS_ONE_MEM, SP_SHORT, 3'h0, 1'b0, 1'b0, 16'h0000, 16'h0000, 1'b0, 1'b0, 6);
    chk_w(16'(mem_wdata_q), 16'h00A4);
    chk_f(fl, 3'b000);
    run(OP_MINUS_ONE_REG, SP_ACC, 3'h0, 1'b1, 1'b0, 16'h0000, 16'h0001, 1'b0, 1'b1, 2);
    chk_f(fl, 3'b101);
    run(OP_PLUS_ONE_MEM, SP_SHORT, 3'h0, 1'b1, 1'b0, 16'h0000, 16'h0000, 1'b0, 1'b0, 4);
    chk_w(16'(mem_wdata_q), 16'h00A5);
  endtask : t_incdec
  task automatic t_pair;
    run(OP_PAIR_PLUS_ONE, SP_ACC, 3'h0, 1'b1, 1'b0, 16'h0000, 16'h00FF, 1'b1, 1'b0, 4);
    chk_w(result_q, 16'h0100);
    chk_f(fl, 3'b010);
    run(OP_PAIR_MINUS_ONE, SP_ACC, 3'h0, 1'b1, 1'b0, 16'h0000, 16'h0000, 1'b0, 1'b1, 4);
    chk_w(result_q, 16'hFFFF);
  endtask : t_pair
  task automatic t_rot;
    cwm_op_type ro[4] = '{OP_ROTATE_RIGHT, OP_ROTATE_LEFT, OP_ROTATE_RIGHT_CY, OP_ROTATE_LEFT_CY};
    logic [7:0] re[4] = '{8'hC0, 8'h03, 8'h40, 8'h02};
    for (int i = 0; i < 4; i++) begin
      run(ro[i], SP_ACC, 3'h0, 1'b1, 1'b0, 16'h8100, 16'h0000, 1'b0, 1'b0, 2);
      chk_w({7'h00, carry_flag_q, result_q[7:0]}, {8'h01, re[i]});
    end
  endtask : t_rot
  task automatic t_bcd;
    run(OP_BCD_FIX_ADD, SP_ACC, 3'h0, 1'b1, 1'b0, 16'h1100, 16'h0000, 1'b1, 1'b0, 4);
    chk_w(result_q, 16'h0017);
    chk_f(fl, 3'b000);
    run(OP_BCD_FIX_ADD, SP_ACC, 3'h0, 1'b1, 1'b0, 16'hA000, 16'h0000, 1'b0, 1'b0, 4);
    chk_f(fl, 3'b101);
    run(OP_BCD_FIX_SUB, SP_ACC, 3'h0, 1'b1, 1'b0, 16'h0F00, 16'h0000, 1'b1, 1'b0, 4);
    chk_w(result_q, 16'h0009);
    chk_f(fl, 3'b000);
  endtask : t_bcd
  task automatic t_bit;
    run(OP_BIT_TO_CARRY, SP_ACC, 3'h7, 1'b1, 1'b0, 16'h8000, 16'h0000, 1'b0, 1'b0, 4);
    chk_f(fl, 3'b001);
    run(OP_CARRY_TO_BIT, SP_SHORT, 3'h1, 1'b1, 1'b0, 16'h0000, 16'h0000, 1'b0, 1'b1, 6);
    chk_w({mem_we_q, result_we_q, 6'h00, mem_wdata_q}, 16'h80A7);
    run(OP_BIT_TO_CARRY, SP_POINTER, 3'h6, 1'b0, 1'b1, 16'h0000, 16'h0000, 1'b0, 1'b1,
        10);
    chk_f(fl, 3'b000);
    run(OP_CARRY_TO_BIT, SP_POINTER, 3'h0, 1'b0, 1'b1, 16'h0000, 16'h0000, 1'b0, 1'b0,
        13);
    chk_w(16'(mem_wdata_q), 16'h00A6);
    run(OP_BIT_TO_CARRY, SP_SPECIAL, 3'h1, 1'b1, 1'b0, 16'h0000, 16'h0000, 1'b0, 1'b0, 7);
    chk_f(fl, 3'b001);
    run(OP_CARRY_TO_BIT, SP_STATUS, 3'h0, 1'b1, 1'b0, 16'h0000, 16'h0000, 1'b0, 1'b1, 8);
    chk_w({mem_we_q, result_we_q, 6'h00, mem_wdata_q}, 16'h80A7);
    run(OP_CARRY_TO_BIT, SP_ACC, 3'h2, 1'b1, 1'b0, 16'h0000, 16'h0000, 1'b0, 1'b1, 4);
    chk_w({result_we_q, 7'h00, result_q[7:0]}, 16'h8004);
  endtask : t_bit
  initial begin
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    t_word();
    t_muldiv();
    t_nibble();
    t_incdec();
    t_pair();
    t_rot();
    t_bcd();
    t_bit();
    end_of_test();
  end
endmodule : cpu_word_mul_rotate_bit_ops_tb
